// [hw/ebt_params.svh]
// Constants for the byte-to-symbol line encoder.
// Assumes inclusion by bare name from the design files.
`ifndef EBT_PARAMS_SVH
`define EBT_PARAMS_SVH
`define EBT_BYTE_W 8
`define EBT_CODE_W 10
`define EBT_LOW_W 5
`define EBT_HIGH_W 3
`define EBT_SIX_W 6
`define EBT_FOUR_W 4
`define EBT_LOW_LSB 0
`define EBT_HIGH_LSB 5
`define EBT_BUF_DEPTH 2
`define EBT_RD_RESET 1'b0
`define EBT_SIX_BAL 3'h3
`define EBT_FOUR_BAL 3'h2
`define EBT_LOW_RUN_EXC 5'h07
`define EBT_HIGH_RUN_EXC 3'h3
`define EBT_HIGH_SEVEN 3'h7
`define EBT_FOUR_PRIMARY 4'hE
`define EBT_FOUR_ALT 4'h7
`endif

// [hw/ebt_pkg.sv]
// Types shared by the line encoder and its word buffer.
// Assumes ebt_params.svh supplies the widths.
`include "ebt_params.svh"
package ebt_pkg;
    typedef logic [`EBT_CODE_W-1:0] ebt_code_type;
    typedef logic [`EBT_BYTE_W-1:0] ebt_byte_type;
    typedef enum logic {EBT_RD_NEG, EBT_RD_POS} ebt_rd_type;
endpackage : ebt_pkg

// [hw/ebt_word_buf.sv]
// Two-entry word buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`include "ebt_params.svh"
module ebt_word_buf
    import ebt_pkg::*;
#(
    parameter int WIDTH = `EBT_CODE_W,
    parameter int DEPTH = `EBT_BUF_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic push_valid,
    output logic push_ready,
    output logic [WIDTH-1:0] pop_data,
    output logic pop_valid,
    input wire logic pop_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] fill;
    wire do_push = push_valid && push_ready;
    wire do_pop = pop_valid && pop_ready;
    // Full is honest: no push while both entries hold words
    assign push_ready = (fill != (AW+1)'(DEPTH));
    assign pop_valid = (fill != '0);
    assign pop_data = mem[rd_idx];
    wire [AW-1:0] wr_idx_inc = (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
    wire [AW-1:0] rd_idx_inc = (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_idx <= '0;
            rd_idx <= '0;
            fill <= '0;
        end else begin
            if (do_push) wr_idx <= wr_idx_inc;
            if (do_pop) rd_idx <= rd_idx_inc;
            fill <= fill + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) mem[wr_idx] <= push_data;
    end

    // A stalled receiver must see the same word until it takes it
    a_word_holds: assert property (@(posedge clk) disable iff (!resetn)
        pop_valid && !pop_ready |=> pop_valid && $stable(pop_data))
        else $error("Held word changed before it was taken");
endmodule : ebt_word_buf

// [hw/ebt_encoder.sv]
// Byte-to-10-bit line encoder with running disparity and output buffer.
// Assumes a byte source and a serializer on CORE_CLK with valid/ready.
// Notes on behaviour
// - Each accepted byte becomes exactly one 10-bit DC-balancing code word.
// - Low five bits map through a 5-to-6 code onto bits a..e,i.
// - High three bits map through a 3-to-4 code onto bits f,g,h,j.
// - A balanced sub-code leaves the running disparity unchanged.
// - Unbalanced sub-code picks +2 when disparity negative, -2 when positive, then flips.
// - Positive 6-bit variant is the bitwise complement of the negative one.
// - Full 32-entry 5-to-6 map; 00000 gives 100111 or 011000.
// - Input 00111 gives 111000 when negative, 000111 when positive.
// - Input 011 gives 1100 when negative, 0011 when positive.
// - Input 111 has primary 1110/0001 and alternate 0111/1000 codes.
`timescale 1ns/1ns
`include "ebt_params.svh"
module ebt_encoder
    import ebt_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic [`EBT_BYTE_W-1:0] IN_DATA,
    input wire logic IN_VALID,
    output logic IN_READY,
    output logic [`EBT_CODE_W-1:0] OUT_CODE,
    output logic OUT_VALID,
    input wire logic OUT_READY
);
    // Negative-disparity form of the 5-to-6 map, a in the top bit
    function automatic logic [`EBT_SIX_W-1:0] six_neg_of(input logic [`EBT_LOW_W-1:0] v);
        logic [`EBT_SIX_W-1:0] r;
        r = 6'h00;
        unique case (v)
            5'h00: r = 6'h27;
            5'h01: r = 6'h1D;
            5'h02: r = 6'h2D;
            5'h03: r = 6'h31;
            5'h04: r = 6'h35;
            5'h05: r = 6'h29;
            5'h06: r = 6'h19;
            5'h07: r = 6'h38;
            5'h08: r = 6'h39;
            5'h09: r = 6'h25;
            5'h0A: r = 6'h15;
            5'h0B: r = 6'h34;
            5'h0C: r = 6'h0D;
            5'h0D: r = 6'h2C;
            5'h0E: r = 6'h1C;
            5'h0F: r = 6'h17;
            5'h10: r = 6'h1B;
            5'h11: r = 6'h23;
            5'h12: r = 6'h13;
            5'h13: r = 6'h32;
            5'h14: r = 6'h0B;
            5'h15: r = 6'h2A;
            5'h16: r = 6'h1A;
            5'h17: r = 6'h3A;
            5'h18: r = 6'h33;
            5'h19: r = 6'h26;
            5'h1A: r = 6'h16;
            5'h1B: r = 6'h36;
            5'h1C: r = 6'h0E;
            5'h1D: r = 6'h2E;
            5'h1E: r = 6'h1E;
            5'h1F: r = 6'h2B;
        endcase
        return r;
    endfunction : six_neg_of

    // Negative-disparity form of the 3-to-4 map, primary seven
    function automatic logic [`EBT_FOUR_W-1:0] four_neg_of(input logic [`EBT_HIGH_W-1:0] v);
        logic [`EBT_FOUR_W-1:0] r;
        r = 4'h0;
        unique case (v)
            3'h0: r = 4'hB;
            3'h1: r = 4'h9;
            3'h2: r = 4'h5;
            3'h3: r = 4'hC;
            3'h4: r = 4'hD;
            3'h5: r = 4'hA;
            3'h6: r = 4'h6;
            3'h7: r = `EBT_FOUR_PRIMARY;
        endcase
        return r;
    endfunction : four_neg_of

    ebt_rd_type rd;
    logic buf_ready;

    wire [`EBT_LOW_W-1:0] low_five_input_bits = IN_DATA[`EBT_LOW_LSB +: `EBT_LOW_W];
    wire [`EBT_HIGH_W-1:0] high_three_input_bits = IN_DATA[`EBT_HIGH_LSB +: `EBT_HIGH_W];
    wire in_fire = IN_VALID && buf_ready;
    wire rd_pos = (rd == EBT_RD_POS);

    // 6-bit sub-code
    wire [`EBT_SIX_W-1:0] six_neg = six_neg_of(low_five_input_bits);
    wire [2:0] six_ones_neg = 3'($countones(six_neg));
    wire six_unbal = (six_ones_neg != `EBT_SIX_BAL);
    wire six_run_exc = (low_five_input_bits == `EBT_LOW_RUN_EXC);
    // Only unbalanced entries and the run exception have two forms
    wire six_flip = six_unbal || six_run_exc;
    wire [`EBT_SIX_W-1:0] six_code = (six_flip && rd_pos) ? ~six_neg : six_neg;
    // Disparity after the 6-bit part; a balanced word keeps it
    wire rd6_pos = rd_pos ^ six_unbal;

    // 4-bit sub-code
    wire high_seven = (high_three_input_bits == `EBT_HIGH_SEVEN);
    // Primary seven after e=i=1 (or 0) would make five equal bits in a row
    wire run_of_five = rd6_pos ? (six_code[1:0] == 2'b00) : (six_code[1:0] == 2'b11);
    wire use_alt = high_seven && run_of_five;
    wire [`EBT_FOUR_W-1:0] primary_seven_code = `EBT_FOUR_PRIMARY;
    wire [`EBT_FOUR_W-1:0] alternate_seven_code = `EBT_FOUR_ALT;
    wire [`EBT_FOUR_W-1:0] four_neg = use_alt ? alternate_seven_code
                                              : four_neg_of(high_three_input_bits);
    wire [2:0] four_ones_neg = 3'($countones(four_neg));
    wire four_unbal = (four_ones_neg != `EBT_FOUR_BAL);
    wire four_run_exc = (high_three_input_bits == `EBT_HIGH_RUN_EXC);
    wire four_flip = four_unbal || four_run_exc;
    wire [`EBT_FOUR_W-1:0] four_code = (four_flip && rd6_pos) ? ~four_neg : four_neg;
    wire next_rd_pos = rd6_pos ^ four_unbal;

    wire [`EBT_CODE_W-1:0] word = {six_code, four_code};

    assign IN_READY = buf_ready;

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            rd <= EBT_RD_NEG;
        end else if (in_fire) begin
            rd <= next_rd_pos ? EBT_RD_POS : EBT_RD_NEG;
        end
    end

    // A stalled serializer fills the buffer, then IN_READY drops
    ebt_word_buf #(
        .WIDTH(`EBT_CODE_W),
        .DEPTH(`EBT_BUF_DEPTH)
    ) u_buf (
        .clk(CORE_CLK),
        .resetn(RESETN),
        .push_data(word),
        .push_valid(IN_VALID),
        .push_ready(buf_ready),
        .pop_data(OUT_CODE),
        .pop_valid(OUT_VALID),
        .pop_ready(OUT_READY)
    );

    // Checking helpers: line disparity of words actually sent
    logic signed [4:0] line_disp;
    wire out_fire = OUT_VALID && OUT_READY;
    wire signed [4:0] out_word_disp = 5'($countones(OUT_CODE)) * 5'sd2 - 5'sd10;
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            line_disp <= -5'sd1;
        end else if (out_fire) begin
            line_disp <= line_disp + out_word_disp;
        end
    end

    default clocking ebt_cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);

    a_byte_to_word: assert property (in_fire |=> OUT_VALID)
        else $error("Accepted byte left no word");
    a_zero_low_map: assert property (in_fire && low_five_input_bits == 5'h00
        |-> six_code == (rd_pos ? 6'h18 : 6'h27))
        else $error("Low zero mapped wrongly");
    a_pos_complement: assert property (in_fire && six_unbal && rd_pos
        |-> six_code == ~six_neg_of(low_five_input_bits))
        else $error("Positive six code not complement");
    a_single_balanced: assert property (in_fire && low_five_input_bits == 5'h03
        |-> six_code == 6'h31)
        else $error("Balanced entry changed with disparity");
    a_low_run_exc: assert property (in_fire && six_run_exc
        |-> six_code == (rd_pos ? 6'h07 : 6'h38) && rd6_pos == rd_pos)
        else $error("Low exception code wrong");
    a_high_run_exc: assert property (in_fire && four_run_exc
        |-> four_code == (rd6_pos ? 4'h3 : 4'hC))
        else $error("High exception code wrong");
    a_balanced_holds: assert property (in_fire && $countones(word) == 5
        |=> rd == $past(rd))
        else $error("Balanced word changed disparity");
    a_unbal_sign: assert property (in_fire && six_unbal
        |-> $countones(six_code) == (rd_pos ? 2 : 4))
        else $error("Unbalanced six picked wrong sign");
    a_seven_forms: assert property (in_fire && high_seven
        |-> ((four_code == 4'hE || four_code == 4'h1) != use_alt)
            && (!use_alt || four_code == (rd6_pos ? 4'h8 : 4'h7)))
        else $error("Seven coded wrongly");
    a_alt_only_run: assert property (in_fire && high_seven
        |-> use_alt == (rd6_pos ? six_code[1:0] == 2'b00 : six_code[1:0] == 2'b11))
        else $error("Alternate seven misused");
    a_reset_negative: assert property (disable iff (1'b0) !RESETN |=> rd == EBT_RD_NEG)
        else $error("Disparity not negative after reset");
    a_line_balance: assert property (line_disp == -5'sd1 || line_disp == 5'sd1)
        else $error("Line disparity out of bounds");
    a_fixed_entries: assert property (in_fire && !rd_pos
        && (low_five_input_bits == 5'h1B || low_five_input_bits == 5'h1D)
        |-> six_code == (low_five_input_bits == 5'h1B ? 6'h36 : 6'h2E))
        else $error("Corrected entries wrong");
endmodule : ebt_encoder

// [tb/ebt_sink.sv]
// Serializer model that collects code words from the encoder.
// Assumes the encoder's valid/ready output on one clock; stall holds it off.
`timescale 1ns/1ns
module ebt_sink
    import ebt_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic stall,
    input wire ebt_code_type code,
    input wire logic valid,
    output logic ready
);
    ebt_code_type q[$];
    // Ready follows stall at once, so the bench can stall in any cycle
    assign ready = !stall;
    always @(posedge clk) begin
        if (resetn && valid && ready) begin
            q.push_back(code);
        end
    end
endmodule : ebt_sink

// [tb/tb_top.sv]
// Self-checking bench for the line encoder with a serializer model.
// Assumes the encoder and sink share CORE_CLK; expectations come from tables here.
`timescale 1ns/1ns
`include "ebt_params.svh"
module tb_top
    import ebt_pkg::*;
;
    logic CORE_CLK = 1'b0;
    logic RESETN = 1'b0;
    ebt_byte_type IN_DATA = 8'h00;
    logic IN_VALID = 1'b0;
    logic IN_READY;
    ebt_code_type OUT_CODE;
    logic OUT_VALID;
    logic OUT_READY;
    logic stall = 1'b0;
    int failures = 0;
    int comparisons = 0;
    logic rd = 1'b0;
    ebt_code_type exp_q[$];
    logic [5:0] t6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13,
        6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E,
        6'h1E, 6'h2B};
    logic [3:0] t4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

    always #50 CORE_CLK = ~CORE_CLK;

    ebt_encoder dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .IN_DATA(IN_DATA),
        .IN_VALID(IN_VALID), .IN_READY(IN_READY), .OUT_CODE(OUT_CODE),
        .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));
    ebt_sink snk (.clk(CORE_CLK), .resetn(RESETN), .stall(stall), .code(OUT_CODE),
        .valid(OUT_VALID), .ready(OUT_READY));

    // Reference coder; rd low means negative disparity
    function automatic ebt_code_type ref_enc(input ebt_byte_type b);
        logic [5:0] s;
        logic [3:0] f;
        int o;
        s = t6[b[4:0]];
        o = $countones(s);
        if (rd && (o != 3 || b[4:0] == 5'h07)) s = ~s;
        if (o != 3) rd = ~rd;
        f = t4[b[7:5]];
        // Alternate only where the primary would extend a run to five
        if (b[7:5] == 3'h7 && ((!rd && s[1:0] == 2'h3) || (rd && s[1:0] == 2'h0))) f = 4'h7;
        o = $countones(f);
        if (rd && (o != 2 || b[7:5] == 3'h3)) f = ~f;
        if (o != 2) rd = ~rd;
        return {s, f};
    endfunction : ref_enc

    task automatic chk_code(input string name, input ebt_code_type e, input ebt_code_type g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask : chk_code

    task automatic chk_bit(input string name, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %b seen %b", name, e, g);
        end
    endtask : chk_bit

    // Entered and left just after a rising edge; valid stays up for back to back
    task automatic send(input ebt_byte_type b);
        int n;
        n = 0;
        IN_DATA = b;
        IN_VALID = 1'b1;
        while (IN_READY !== 1'b1 && n < 50) begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
        if (n >= 50) failures++;
        exp_q.push_back(ref_enc(b));
        @(posedge CORE_CLK);
        #1;
    endtask : send

    task automatic drain();
        int n;
        n = 0;
        IN_VALID = 1'b0;
        while (snk.q.size() < exp_q.size() && n < 100) begin
            @(posedge CORE_CLK);
            #1;
            n++;
        end
        chk_bit("word count", 1'b1, snk.q.size() == exp_q.size());
        while (exp_q.size() > 0 && snk.q.size() > 0) begin
            chk_code("code word", exp_q.pop_front(), snk.q.pop_front());
        end
        exp_q.delete();
        snk.q.delete();
    endtask : drain

    task automatic t_reset_state();
        chk_bit("in ready", 1'b1, IN_READY);
        chk_bit("out valid", 1'b0, OUT_VALID);
    endtask : t_reset_state

    task automatic t_first_word();
        send(8'h00);
        // Drain lowers IN_VALID in this same step, before the next edge
        chk_bit("out valid", 1'b1, OUT_VALID);
        chk_code("first word", 10'h274, OUT_CODE);
        drain();
    endtask : t_first_word

    task automatic t_all_bytes();
        for (int p = 0; p < 2; p++) begin
            // A disparity flip between passes moves each byte to the other side
            if (p == 1) send(8'h03);
            for (int k = 0; k < 256; k++) begin
                send(k[7:0]);
            end
        end
        drain();
    endtask : t_all_bytes

    task automatic t_stall();
        stall = 1'b1;
        send(8'hFF);
        send(8'hE7);
        chk_bit("in ready full", 1'b0, IN_READY);
        IN_DATA = 8'h7B;
        repeat (3) @(posedge CORE_CLK);
        #1;
        chk_bit("out valid held", 1'b1, OUT_VALID);
        stall = 1'b0;
        send(8'h7B);
        drain();
    endtask : t_stall

    task automatic results();
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    initial begin
        repeat (4) @(posedge CORE_CLK);
        #1;
        RESETN = 1'b1;
        t_reset_state();
        t_first_word();
        t_all_bytes();
        t_stall();
        results();
    end

    initial begin
        repeat (5000) @(posedge CORE_CLK);
        failures++;
        results();
    end
endmodule : tb_top
